// ### verilog/fss_slave.sv
// fss_slave.sv: link state machine of a fieldbus drive slave with power stage coupling
// assumes: master register port and drive requests are on clk; info store port on clk
//
// Overview of operation
// - four states: boot, config, safe-run, run
// - upward moves go one step at a time
// - downward moves from run may skip states
// - state changes only on master control writes
// - perform request, report outcome in status register
// - failed request raises error flag
// - boot: registers only, no application traffic
// - config: mailbox on, process data off
// - safe-run: traffic runs, outputs not applied
// - run: mailbox and process data both valid
// - not-ready only in boot; ready/on outside
// - operation enabled accepted only in run
// - command down to boot disables power stage
// - any command during operation disables power stage
// - power stage error leaves bus state alone
// - info store layout fixed by word address
// - copy info words 0..7 at initialisation
`default_nettype none
`include "fss_params.svh"

module fss_slave #(
    parameter int TRANS_CYCLES = `FSS_TRANS_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    output logic reg_rd_valid,
    output logic store_rd,
    output logic [15:0] store_addr,
    input wire logic [15:0] store_data,
    input wire logic store_valid,
    input wire logic drive_req_valid,
    input wire fss_pkg::fss_power_type drive_req_state,
    input wire logic drive_fault,
    output fss_pkg::fss_power_type drive_power_state,
    output fss_pkg::fss_bus_state_type link_state,
    output logic transition_busy,
    output logic mailbox_enable,
    output logic process_data_enable,
    output logic outputs_apply_enable
);
    import fss_pkg::*;

    if (TRANS_CYCLES < 1 || TRANS_CYCLES > 255) begin : gen_bad_trans
        $error("TRANS_CYCLES must be 1..255");
    end

    // ------------------------------------------------------------------------
    // state record
    // ------------------------------------------------------------------------
    typedef struct packed {
        fss_bus_state_type bus;
        fss_bus_state_type target;
        logic busy;
        logic [7:0] cnt;
        logic err;
        logic [15:0] err_code;
        logic [15:0] station;
        logic [15:0] ctrl;
        logic [15:0] alias_adr;
        logic [15:0] pdi_ctrl;
        logic [15:0] pdi_cfg;
        logic [15:0] pdi_ext;
        logic [15:0] sync_len;
        fss_power_type pwr;
        logic [15:0] rd_data;
        logic rd_valid;
        logic mbx_en;
        logic pd_en;
        logic out_en;
    } fss_slave_type;

    fss_slave_type q;
    fss_slave_type next_q;
    logic ld_we;
    logic [2:0] ld_idx;
    logic [15:0] ld_data;
    logic ld_done;

    // code of a state as shown to the master
    function automatic logic [3:0] state_code(input fss_bus_state_type s);
        case (s)
            FSS_BOOT: state_code = `FSS_CODE_BOOT;
            FSS_CONFIG: state_code = `FSS_CODE_CONFIG;
            FSS_SAFE_RUN: state_code = `FSS_CODE_SAFE;
            default: state_code = `FSS_CODE_RUN;
        endcase
    endfunction

    // upward by exactly one step, or any step downward or in place
    function automatic logic legal_move(input fss_bus_state_type from, input fss_bus_state_type to);
        legal_move = (to <= from) || (2'(to) == 2'(from) + 2'h1);
    endfunction

    // ------------------------------------------------------------------------
    // info store loader
    // ------------------------------------------------------------------------
    fss_info_loader #(
        .WORDS(`FSS_INFO_CFG_WORDS)
    ) fss_info_loader_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .store_rd(store_rd),
        .store_addr(store_addr),
        .store_data(store_data),
        .store_valid(store_valid),
        .word_we(ld_we),
        .word_idx(ld_idx),
        .word_data(ld_data),
        .load_done(ld_done)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        logic [3:0] req_code;
        fss_bus_state_type req_state;
        logic req_known;
        logic cmd_taken;
        logic bus_live;
        req_code = reg_wr_data[`FSS_STATE_MSB:`FSS_STATE_LSB];
        req_state = FSS_BOOT;
        req_known = 1'b1;
        cmd_taken = 1'b0;
        // outside boot and not on the way back into it
        bus_live = (q.bus != FSS_BOOT) && !(q.busy && q.target == FSS_BOOT);
        next_q = q;
        next_q.rd_valid = 1'b0;

        // configuration words land in their registers once
        if (ld_we) begin
            case (ld_idx)
                `FSS_INFO_IDX_PDI_CTRL: next_q.pdi_ctrl = ld_data;
                `FSS_INFO_IDX_PDI_CFG: next_q.pdi_cfg = ld_data;
                `FSS_INFO_IDX_SYNC_LEN: next_q.sync_len = ld_data;
                `FSS_INFO_IDX_PDI_EXT: next_q.pdi_ext = ld_data;
                `FSS_INFO_IDX_ALIAS: next_q.alias_adr = ld_data;
                default: next_q.alias_adr = q.alias_adr; // checksum and reserved words
            endcase
        end

        // register reads answer one cycle later; unmapped reads give zero
        if (reg_rd_en) begin
            next_q.rd_valid = 1'b1;
            case (reg_addr)
                `FSS_ADDR_STATION: next_q.rd_data = q.station;
                `FSS_ADDR_ALIAS: next_q.rd_data = q.alias_adr;
                `FSS_ADDR_CONTROL: next_q.rd_data = q.ctrl;
                `FSS_ADDR_STATUS: next_q.rd_data = {11'h000, q.err, state_code(q.bus)};
                `FSS_ADDR_STATUS_CODE: next_q.rd_data = q.err_code;
                `FSS_ADDR_PDI_CTRL: next_q.rd_data = q.pdi_ctrl;
                `FSS_ADDR_PDI_CFG: next_q.rd_data = q.pdi_cfg;
                `FSS_ADDR_PDI_EXT: next_q.rd_data = q.pdi_ext;
                `FSS_ADDR_SYNC_LEN: next_q.rd_data = q.sync_len;
                default: next_q.rd_data = 16'h0000;
            endcase
        end

        // transition in progress; the master must wait it out
        if (q.busy) begin
            if (q.cnt == 8'h01) begin
                next_q.busy = 1'b0;
                next_q.bus = q.target;
                if (q.target != FSS_BOOT && q.pwr == FSS_PWR_NOT_READY) begin
                    next_q.pwr = FSS_PWR_ON_DISABLED;
                end
            end
            next_q.cnt = q.cnt - 8'h01;
        end

        if (reg_wr_en && reg_addr == `FSS_ADDR_STATION) begin
            next_q.station = reg_wr_data;
        end

        // a control write is the only way the bus state moves
        if (reg_wr_en && reg_addr == `FSS_ADDR_CONTROL && ld_done && !q.busy) begin
            next_q.ctrl = reg_wr_data;
            cmd_taken = 1'b1;
            if (reg_wr_data[`FSS_ERR_BIT]) begin
                next_q.err = 1'b0;
                next_q.err_code = `FSS_ERRC_NONE;
            end
            case (req_code)
                `FSS_CODE_BOOT: req_state = FSS_BOOT;
                `FSS_CODE_CONFIG: req_state = FSS_CONFIG;
                `FSS_CODE_SAFE: req_state = FSS_SAFE_RUN;
                `FSS_CODE_RUN: req_state = FSS_RUN;
                default: req_known = 1'b0;
            endcase
            // state stays shown while the error is raised
            if (!req_known) begin
                next_q.err = 1'b1;
                next_q.err_code = `FSS_ERRC_BAD_STATE;
            end else if (!legal_move(q.bus, req_state)) begin
                next_q.err = 1'b1;
                next_q.err_code = `FSS_ERRC_BAD_TRANS;
            end else begin
                next_q.busy = 1'b1;
                next_q.cnt = 8'(TRANS_CYCLES);
                next_q.target = req_state;
            end
            if (q.pwr == FSS_PWR_OP_ENABLED) begin
                next_q.pwr = FSS_PWR_ON_DISABLED;
            end
            if (req_known && req_state == FSS_BOOT && q.bus != FSS_BOOT &&
                q.pwr != FSS_PWR_FAULT_REACT && q.pwr != FSS_PWR_FAULT) begin
                next_q.pwr = FSS_PWR_ON_DISABLED;
            end
        end

        // power stage; a fault never touches the bus fields
        if (drive_fault && q.pwr != FSS_PWR_FAULT) begin
            next_q.pwr = FSS_PWR_FAULT_REACT;
        end else if (q.pwr == FSS_PWR_FAULT_REACT) begin
            next_q.pwr = FSS_PWR_FAULT;
        end else if (drive_req_valid && !cmd_taken) begin
            case (drive_req_state)
                FSS_PWR_ON_DISABLED: begin
                    if (q.pwr != FSS_PWR_NOT_READY) next_q.pwr = FSS_PWR_ON_DISABLED;
                end
                FSS_PWR_READY: begin
                    if (bus_live && (q.pwr == FSS_PWR_ON_DISABLED ||
                        q.pwr == FSS_PWR_SWITCHED_ON)) next_q.pwr = FSS_PWR_READY;
                end
                FSS_PWR_SWITCHED_ON: begin
                    if (bus_live && (q.pwr == FSS_PWR_READY ||
                        q.pwr == FSS_PWR_OP_ENABLED)) next_q.pwr = FSS_PWR_SWITCHED_ON;
                end
                FSS_PWR_OP_ENABLED: begin
                    if (q.bus == FSS_RUN && !q.busy &&
                        q.pwr == FSS_PWR_SWITCHED_ON) next_q.pwr = FSS_PWR_OP_ENABLED;
                end
                // keep what the bus logic above chose, e.g. leaving not-ready
                default: next_q.pwr = next_q.pwr;
            endcase
        end

        // traffic gates follow the state being entered
        next_q.mbx_en = (next_q.bus != FSS_BOOT);
        next_q.pd_en = (next_q.bus == FSS_SAFE_RUN) || (next_q.bus == FSS_RUN);
        next_q.out_en = (next_q.bus == FSS_RUN);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{bus: FSS_BOOT, target: FSS_BOOT, pwr: FSS_PWR_NOT_READY, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign reg_rd_data = q.rd_data;
    assign reg_rd_valid = q.rd_valid;
    assign drive_power_state = q.pwr;
    assign link_state = q.bus;
    assign transition_busy = q.busy;
    assign mailbox_enable = q.mbx_en;
    assign process_data_enable = q.pd_en;
    assign outputs_apply_enable = q.out_en;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    chk_count_states: assert property (@(posedge clk) disable iff (sys_rst)
        q.busy |-> (q.target inside {FSS_BOOT, FSS_CONFIG, FSS_SAFE_RUN, FSS_RUN}))
        else $error("target outside the four states");

    chk_no_skip_up: assert property (@(posedge clk) disable iff (sys_rst)
        q.bus > $past(q.bus) |-> 2'(q.bus) == 2'($past(q.bus)) + 2'h1)
        else $error("upward move skipped a state");

    chk_only_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        q.bus != $past(q.bus) |-> $past(q.busy) && $past(q.cnt) == 8'h01)
        else $error("bus state moved without a request");

    chk_trans_done: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(q.busy) |-> ##[1:255] (!q.busy && q.bus == q.target))
        else $error("transition not completed in time");

    chk_err_keeps: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(q.err) && !q.busy |-> q.bus == $past(q.bus))
        else $error("rejected request moved the state");

    chk_boot_gates: assert property (@(posedge clk) disable iff (sys_rst)
        q.bus == FSS_BOOT |-> !mailbox_enable && !process_data_enable)
        else $error("traffic enabled in boot");

    chk_cfg_gates: assert property (@(posedge clk) disable iff (sys_rst)
        q.bus == FSS_CONFIG |-> mailbox_enable && !process_data_enable)
        else $error("config gates wrong");

    chk_safe_out: assert property (@(posedge clk) disable iff (sys_rst)
        q.bus == FSS_SAFE_RUN |-> process_data_enable && !outputs_apply_enable)
        else $error("outputs applied in safe-run");

    chk_not_ready: assert property (@(posedge clk) disable iff (sys_rst)
        q.pwr == FSS_PWR_NOT_READY |-> q.bus == FSS_BOOT)
        else $error("not ready outside boot");

    chk_boot_pwr_off: assert property (@(posedge clk) disable iff (sys_rst)
        q.bus == FSS_BOOT |->
        !(q.pwr inside {FSS_PWR_READY, FSS_PWR_SWITCHED_ON, FSS_PWR_OP_ENABLED}))
        else $error("power stage on while in boot");

    chk_op_in_run: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(q.pwr == FSS_PWR_OP_ENABLED) |-> $past(q.bus) == FSS_RUN)
        else $error("operation enabled outside run");

    chk_cmd_disable: assert property (@(posedge clk) disable iff (sys_rst)
        q.pwr == FSS_PWR_OP_ENABLED && reg_wr_en && reg_addr == `FSS_ADDR_CONTROL &&
        !q.busy && ld_done && !drive_fault |=> q.pwr == FSS_PWR_ON_DISABLED)
        else $error("command left power stage enabled");

    chk_fault_bus: assert property (@(posedge clk) disable iff (sys_rst)
        drive_fault && !q.busy && !(reg_wr_en && reg_addr == `FSS_ADDR_CONTROL)
        |=> q.bus == $past(q.bus))
        else $error("fault changed bus state");
endmodule

`default_nettype wire

// ### verilog/fss_params.svh
// fss_params.svh: offsets, field positions, codes and timing for the link state machine
// assumes: included by bare name from the design modules
`ifndef FSS_PARAMS_SVH
`define FSS_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses of 16-bit words)
// ----------------------------------------------------------------------------
`define FSS_ADDR_STATION 16'h0010
`define FSS_ADDR_ALIAS 16'h0012
`define FSS_ADDR_CONTROL 16'h0120
`define FSS_ADDR_STATUS 16'h0130
`define FSS_ADDR_STATUS_CODE 16'h0134
`define FSS_ADDR_PDI_CTRL 16'h0140
`define FSS_ADDR_PDI_CFG 16'h0150
`define FSS_ADDR_PDI_EXT 16'h0152
`define FSS_ADDR_SYNC_LEN 16'h0982

// ----------------------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------------------
`define FSS_STATE_LSB 0
`define FSS_STATE_MSB 3
`define FSS_ERR_BIT 4
`define FSS_CODE_BOOT 4'h1
`define FSS_CODE_CONFIG 4'h2
`define FSS_CODE_SAFE 4'h4
`define FSS_CODE_RUN 4'h8
`define FSS_ERRC_NONE 16'h0000
`define FSS_ERRC_BAD_TRANS 16'h0011
`define FSS_ERRC_BAD_STATE 16'h0012

// ----------------------------------------------------------------------------
// device info store layout (word addresses)
// ----------------------------------------------------------------------------
`define FSS_INFO_CFG_BASE 16'h0000
`define FSS_INFO_CFG_WORDS 8
`define FSS_INFO_ID_BASE 16'h0008
`define FSS_INFO_DELAY_BASE 16'h0010
`define FSS_INFO_MBX_BASE 16'h0018
`define FSS_INFO_SIZE_BASE 16'h0038
`define FSS_INFO_CAT_BASE 16'h0040
`define FSS_INFO_IDX_PDI_CTRL 3'h0
`define FSS_INFO_IDX_PDI_CFG 3'h1
`define FSS_INFO_IDX_SYNC_LEN 3'h2
`define FSS_INFO_IDX_PDI_EXT 3'h3
`define FSS_INFO_IDX_ALIAS 3'h4

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define FSS_CLK_PERIOD_NS 25
`define FSS_TRANS_TIME_NS 1000
`define FSS_TRANS_CYCLES ((`FSS_TRANS_TIME_NS + `FSS_CLK_PERIOD_NS - 1) / `FSS_CLK_PERIOD_NS)

`endif

// ### verilog/fss_pkg.sv
// fss_pkg.sv: types shared by the link state machine and its info store loader
// assumes: fss_params.svh is on the include path
`default_nettype none

package fss_pkg;
    // communication states of the link state machine
    typedef enum logic [1:0] {
        FSS_BOOT,
        FSS_CONFIG,
        FSS_SAFE_RUN,
        FSS_RUN
    } fss_bus_state_type;

    // drive power stage states
    typedef enum logic [2:0] {
        FSS_PWR_NOT_READY,
        FSS_PWR_ON_DISABLED,
        FSS_PWR_READY,
        FSS_PWR_SWITCHED_ON,
        FSS_PWR_OP_ENABLED,
        FSS_PWR_FAULT_REACT,
        FSS_PWR_FAULT
    } fss_power_type;

    typedef enum logic [1:0] {
        FSS_LD_IDLE,
        FSS_LD_READ,
        FSS_LD_WAIT,
        FSS_LD_DONE
    } fss_load_state_type;
endpackage

`default_nettype wire

// ### verilog/fss_info_loader.sv
// fss_info_loader.sv: copies the configuration words of the device info store after reset
// assumes: a same-clock store read port answering with store_valid some cycles later
`default_nettype none
`include "fss_params.svh"

module fss_info_loader #(
    parameter int WORDS = `FSS_INFO_CFG_WORDS
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic store_rd,
    output logic [15:0] store_addr,
    input wire logic [15:0] store_data,
    input wire logic store_valid,
    output logic word_we,
    output logic [2:0] word_idx,
    output logic [15:0] word_data,
    output logic load_done
);
    import fss_pkg::*;

    // the word index is three bits wide, so more than eight words cannot be addressed
    if (WORDS < 1 || WORDS > 8) begin : gen_bad_words
        $error("loader serves one to eight words");
    end

    typedef struct packed {
        fss_load_state_type st;
        logic [2:0] idx;
        logic [2:0] widx;
        logic rd;
        logic we;
        logic [15:0] data;
        logic done;
    } fss_loader_type;

    fss_loader_type q;
    fss_loader_type next_q;

    // ------------------------------------------------------------------------
    // sequencer: one word at a time, strictly in address order
    // ------------------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.rd = 1'b0;
        next_q.we = 1'b0;
        case (q.st)
            FSS_LD_IDLE: begin
                next_q.st = FSS_LD_READ;
            end
            FSS_LD_READ: begin
                next_q.rd = 1'b1;
                next_q.st = FSS_LD_WAIT;
            end
            FSS_LD_WAIT: begin
                if (store_valid) begin
                    next_q.we = 1'b1;
                    next_q.data = store_data;
                    next_q.widx = q.idx; // index of the word now landing
                    if (q.idx == 3'(WORDS - 1)) begin
                        next_q.st = FSS_LD_DONE;
                        next_q.done = 1'b1;
                    end else begin
                        next_q.idx = q.idx + 3'h1;
                        next_q.st = FSS_LD_READ;
                    end
                end
            end
            default: begin
                next_q.st = FSS_LD_DONE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: FSS_LD_IDLE, default: '0};
        end else begin
            q <= next_q;
        end
    end

    // idx already points at the next word during the write pulse, so widx keeps the old one
    assign store_rd = q.rd;
    assign store_addr = `FSS_INFO_CFG_BASE + {13'h0000, q.idx};
    assign word_we = q.we;
    assign word_idx = q.widx;
    assign word_data = q.data;
    assign load_done = q.done;
endmodule

`default_nettype wire

// ### sim/fss_info_store_model.sv
// fss_info_store_model.sv: behavioural device info store for the loader port
// assumes: same clock as the slave; each word is a fixed pattern of its address
`default_nettype none

module fss_info_store_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic store_rd,
    input wire logic [15:0] store_addr,
    output logic [15:0] store_data,
    output logic store_valid
);
    logic [15:0] addr_q;
    logic [1:0] wait_cnt;
    logic pending;
    logic slow;

    // alternate prompt and slow answers; the loader has no timeout of its own
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q <= 16'h0;
            wait_cnt <= 2'h0;
            pending <= 1'b0;
            slow <= 1'b0;
            store_valid <= 1'b0;
            store_data <= 16'h0;
        end else begin
            store_valid <= 1'b0;
            store_data <= ~store_data;  // data is not held once the strobe is gone
            if (store_rd) begin
                addr_q <= store_addr;
                pending <= 1'b1;
                wait_cnt <= slow ? 2'h3 : 2'h0;
                slow <= ~slow;
            end else if (pending && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (pending) begin
                pending <= 1'b0;
                store_valid <= 1'b1;
                store_data <= 16'ha500 | addr_q;
            end
        end
    end
endmodule

`default_nettype wire

// ### sim/test_fss_slave.sv
// test_fss_slave.sv: self-checking bench; the bench plays the bus master
// assumes: fss_slave with a short transition time and the info store model
`default_nettype none

module test_fss_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import fss_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, drive_req_valid = 1'b0, drive_fault = 1'b0;
    logic [15:0] reg_addr = 16'h0, reg_wr_data = 16'h0, reg_rd_data, store_addr, store_data;
    logic reg_rd_valid, store_rd, store_valid, transition_busy;
    logic mailbox_enable, process_data_enable, outputs_apply_enable;
    fss_power_type drive_req_state = FSS_PWR_NOT_READY;
    fss_power_type drive_power_state;
    fss_bus_state_type link_state;
    logic [15:0] exp_q[$];
    logic [15:0] info_dst[5] = '{16'h0140, 16'h0150, 16'h0982, 16'h0152, 16'h0012};
    logic [15:0] v;
    int mismatches = 0, n_tests = 0, cycles = 0, k;
    integer seed = 41;

    fss_slave #(.TRANS_CYCLES(2)) fss_slave_i (.clk, .sys_rst, .reg_wr_en, .reg_rd_en,
        .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid, .store_rd, .store_addr,
        .store_data, .store_valid, .drive_req_valid, .drive_req_state, .drive_fault,
        .drive_power_state, .link_state, .transition_busy, .mailbox_enable,
        .process_data_enable, .outputs_apply_enable);
    fss_info_store_model fss_info_store_model_i (.clk, .sys_rst, .store_rd, .store_addr,
        .store_data, .store_valid);

    initial begin
        forever #12.5 clk = ~clk;
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    // expectation is queued before the strobe so the monitor always finds it
    task automatic rd(logic [15:0] a, logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
    endtask

    task automatic drv(fss_power_type s, fss_power_type e);
        @(posedge clk);
        drive_req_valid <= 1'b1;
        drive_req_state <= s;
        @(posedge clk);
        drive_req_valid <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        chk("drive_power_state", 16'(drive_power_state), 16'(e));
    endtask

    // control write, bounded wait for the transition, then state and status
    task automatic req(logic [15:0] d, fss_bus_state_type s, logic [15:0] st);
        wr(16'h0120, d);
        k = 0;
        @(negedge clk);
        while (transition_busy !== 1'b0 && k < 50) begin
            @(negedge clk);
            k++;
        end
        chk("transition_busy", {15'h0, transition_busy}, 16'h0);
        chk("link_state", 16'(link_state), 16'(s));
        rd(16'h0130, st);
    endtask

    // read answers are matched in order against the queued expectations
    always @(posedge clk) begin
        if (reg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("spare_read", 16'h0, 16'hffff);
            else chk("reg_rd_data", reg_rd_data, exp_q.pop_front());
        end
    end

    // hang guard, well beyond the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            close_out();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        wr(16'h0120, 16'h0002);  // dropped: info words still loading
        repeat (150) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(info_dst[i], 16'ha500 | 16'(i));
        end
        rd(16'h0130, 16'h0001);
        @(negedge clk);
        chk("mailbox_enable", {15'h0, mailbox_enable}, 16'h0);
        chk("drive_power_state", 16'(drive_power_state), 16'(FSS_PWR_NOT_READY));
        v = 16'($random(seed));
        wr(16'h0010, v);
        rd(16'h0010, v);
        rd(16'h0ffe, 16'h0);
        req(16'h0008, FSS_BOOT, 16'h0011);
        rd(16'h0134, 16'h0011);
        req(16'h0013, FSS_BOOT, 16'h0011);
        rd(16'h0134, 16'h0012);
        req(16'h0012, FSS_CONFIG, 16'h0002);
        chk("mailbox_enable", {15'h0, mailbox_enable}, 16'h1);
        chk("process_data_enable", {15'h0, process_data_enable}, 16'h0);
        drv(FSS_PWR_OP_ENABLED, FSS_PWR_ON_DISABLED);
        drv(FSS_PWR_READY, FSS_PWR_READY);
        req(16'h0008, FSS_CONFIG, 16'h0012);
        req(16'h0014, FSS_SAFE_RUN, 16'h0004);
        chk("process_data_enable", {15'h0, process_data_enable}, 16'h1);
        chk("outputs_apply_enable", {15'h0, outputs_apply_enable}, 16'h0);
        req(16'h0008, FSS_RUN, 16'h0008);
        chk("outputs_apply_enable", {15'h0, outputs_apply_enable}, 16'h1);
        drv(FSS_PWR_SWITCHED_ON, FSS_PWR_SWITCHED_ON);
        drv(FSS_PWR_OP_ENABLED, FSS_PWR_OP_ENABLED);
        req(16'h0008, FSS_RUN, 16'h0008);
        chk("drive_power_state", 16'(drive_power_state), 16'(FSS_PWR_ON_DISABLED));
        drv(FSS_PWR_READY, FSS_PWR_READY);
        @(posedge clk);
        drive_fault <= 1'b1;
        @(posedge clk);
        drive_fault <= 1'b0;
        repeat (3) @(negedge clk);
        chk("drive_power_state", 16'(drive_power_state), 16'(FSS_PWR_FAULT));
        chk("link_state", 16'(link_state), 16'(FSS_RUN));
        drv(FSS_PWR_ON_DISABLED, FSS_PWR_ON_DISABLED);
        drv(FSS_PWR_READY, FSS_PWR_READY);
        req(16'h0001, FSS_BOOT, 16'h0001);
        chk("drive_power_state", 16'(drive_power_state), 16'(FSS_PWR_ON_DISABLED));
        chk("mailbox_enable", {15'h0, mailbox_enable}, 16'h0);
        repeat (4) @(posedge clk);
        chk("pending_reads", 16'(exp_q.size()), 16'h0);
        close_out();
    end
endmodule

`default_nettype wire
